// ---- verilog/pec_counter.sv ----
// Per-core performance event counter with a classic Wishbone register slave
// Operation
// - Count the selected condition only while the core is active.
// - A halted core that is being snooped still counts as active.
// - Unit mask bits 15:14 choose this core only or either core.
// - Subfield 11B counts the condition for all cores alike.
// - Event 3CH cycle counts never advance while halted, even when snooped.
// - Bus data-ready clocks with mask 20H count every bus agent.
// - Event 30H counts cycles the second cache refuses requests.
// - Event 32H counts cycles with no request to the second cache.
// - Event 3C mask 00H counts unhalted core clock cycles.
// - Event 3C mask 01H counts unhalted bus clock cycles.
// - Event 3C mask 02H counts bus cycles running while other core halts.
// - Event 4FH counts first cache prefetch requests, resubmissions included.
// - Event 78H mask 01H counts cross-core snoops of the data cache unit.
// - Cross-core snoops use the store port and stall ordinary stores.
// - Event 7DH counts bus cycles with no outstanding transaction.
// - Event 77H counts clean, hit and hit-modified external snoop responses.
`timescale 1ns/1ps
`include "pec_params.svh"
module pec_counter (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire pec_pkg::pec_word_t wb_dat_i,
    output pec_pkg::pec_word_t    wb_dat_o,
    output logic                  wb_ack_o,
    // Core condition inputs, asynchronous to sys_clk
    input  wire logic             coreRunning,
    input  wire logic             coreSnooped,
    input  wire logic             otherCoreRunning,
    input  wire logic             otherCoreSnooped,
    input  wire logic             busClockTick,
    input  wire logic             cacheRefuse,
    input  wire logic             cacheRefuseOther,
    input  wire logic             cacheIdleRequest,
    input  wire logic             cacheIdleRequestOther,
    input  wire logic             prefetchRequest,
    input  wire logic             prefetchRequestOther,
    input  wire logic             crossCoreSnoop,
    input  wire logic             busOutstanding,
    input  wire logic             busDataReadyOwn,
    input  wire logic             busDataReadyAny,
    input  wire logic             snoopResponse,
    input  wire logic             storeRequest,
    // Store port arbitration and core activity flag
    output logic                  storeGrant,
    output logic                  snoopOnStorePort,
    output logic                  counterActive
);
    import pec_pkg::*;

    localparam int NSYNC = 17;

    logic [NSYNC-1:0] syncIn;
    logic [NSYNC-1:0] syncCond;
    pec_word_t        sel_ff;
    pec_count_t       count_ff;
    pec_count_t       nxt_count;
    pec_word_t        nxt_datO;
    logic             storeGrant_ff;
    logic             snoopPort_ff;
    logic             active_ff;
    logic             busTickPrev_ff;

    // Gather all pin-side conditions for the synchroniser
    assign syncIn = {coreRunning, coreSnooped, otherCoreRunning, otherCoreSnooped,
                     busClockTick, cacheRefuse, cacheRefuseOther, cacheIdleRequest,
                     cacheIdleRequestOther, prefetchRequest, prefetchRequestOther,
                     crossCoreSnoop, busOutstanding, busDataReadyOwn, busDataReadyAny,
                     snoopResponse, storeRequest};

    pec_sync #(.WIDTH(NSYNC)) uSync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .asyncIn (syncIn),
        .syncOut (syncCond)
    );

    // Named synchronised conditions
    wire logic sRun      = syncCond[16];
    wire logic sSnooped  = syncCond[15];
    wire logic sOthRun   = syncCond[14];
    wire logic sOthSnp   = syncCond[13];
    wire logic sBusTick  = syncCond[12];
    wire logic sRej      = syncCond[11];
    wire logic sRejO     = syncCond[10];
    wire logic sIdle     = syncCond[9];
    wire logic sIdleO    = syncCond[8];
    wire logic sPref     = syncCond[7];
    wire logic sPrefO    = syncCond[6];
    wire logic sXSnoop   = syncCond[5];
    wire logic sBusOut   = syncCond[4];
    wire logic sDrdyOwn  = syncCond[3];
    wire logic sDrdyAny  = syncCond[2];
    wire logic sSnpResp  = syncCond[1];
    wire logic sStoreReq = syncCond[0];

    // Selects a per-core or all-core view of a shared condition
    function automatic logic pickScope(input logic [1:0] scope, input logic own, input logic other);
        pickScope = (scope == `PEC_CORE_ALL) ? (own | other) : own;
    endfunction

    // Event-select fields
    wire pec_code_t  evtCode = sel_ff[`PEC_EVT_MSB:`PEC_EVT_LSB];
    wire pec_code_t  uMask   = sel_ff[`PEC_UMASK_MSB:`PEC_UMASK_LSB];
    wire logic [1:0] scope   = sel_ff[`PEC_CORE_MSB:`PEC_CORE_LSB];
    wire logic       enable  = sel_ff[`PEC_EN_BIT];
    wire pec_code_t  lowMask = {2'h0, uMask[5:0]};

    // Activity: running code, or halted but snooped through coreSnooped (otherCoreSnooped only feeds the status register)
    wire logic coreActive = sRun | sSnooped;
    wire logic busEdge    = sBusTick & ~busTickPrev_ff;

    // Per-event hit decode
    wire logic hitRej    = (evtCode == `PEC_EV_L2REJ) & pickScope(scope, sRej, sRejO);
    wire logic hitIdle   = (evtCode == `PEC_EV_L2IDLE) & pickScope(scope, sIdle, sIdleO);
    wire logic isUnhalt  = (evtCode == `PEC_EV_UNHALT);
    wire logic hitCore   = isUnhalt & (uMask == `PEC_UM_CORECYC) & sRun;
    wire logic hitRef    = isUnhalt & (uMask == `PEC_UM_REFCYC) & sRun & busEdge;
    wire logic hitSerial = isUnhalt & (uMask == `PEC_UM_SERIAL) & sRun & ~sOthRun & busEdge;
    wire logic hitPref   = (evtCode == `PEC_EV_L1PREF) & (lowMask == `PEC_UM_CORECYC)
                           & pickScope(scope, sPref, sPrefO);
    wire logic hitXSnoop = (evtCode == `PEC_EV_XSNOOP) & (lowMask == `PEC_UM_REFCYC) & sXSnoop;
    wire logic hitBusIdl = (evtCode == `PEC_EV_BUSIDLE) & (lowMask == `PEC_UM_CORECYC)
                           & ~sBusOut & busEdge;
    wire logic hitSnpRsp = (evtCode == `PEC_EV_BUSSNP) & (lowMask == `PEC_UM_CORECYC) & sSnpResp;
    wire logic drdyAll   = (uMask == `PEC_UM_ALLAGENT) | (scope == `PEC_CORE_ALL);
    wire logic hitDrdy   = (evtCode == `PEC_EV_DRDY) & (drdyAll ? sDrdyAny : sDrdyOwn);

    // Cycle events already carry their own halt qualification
    wire logic hitCycle  = hitCore | hitRef | hitSerial;
    wire logic hitOther  = hitRej | hitIdle | hitPref | hitXSnoop | hitBusIdl | hitSnpRsp | hitDrdy;
    wire logic doCount   = enable & (hitCycle | (hitOther & coreActive));

    // Wishbone decode
    wire logic wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wbWrite  = wbReq & wb_we_i;
    wire logic wrSel    = wbWrite & (wb_adr_i == `PEC_ADR_SEL);
    wire logic wrCntLo  = wbWrite & (wb_adr_i == `PEC_ADR_CNT_LO);
    wire logic wrCntHi  = wbWrite & (wb_adr_i == `PEC_ADR_CNT_HI);

    // Byte-lane merge for register writes
    function automatic pec_word_t laneMerge(input pec_word_t old, input pec_word_t dat, input logic [3:0] sel);
        pec_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        laneMerge = r;
    endfunction

    // Next counter value: software write wins over counting
    always_comb begin
        nxt_count = count_ff;
        if (wrCntLo) begin
            nxt_count[31:0] = laneMerge(count_ff[31:0], wb_dat_i, wb_sel_i);
        end else if (wrCntHi) begin
            nxt_count[39:32] = wb_sel_i[0] ? wb_dat_i[7:0] : count_ff[39:32];
        end else if (doCount) begin
            nxt_count = count_ff + `PEC_CNT_ONE;
        end
    end

    // Read data multiplexer, unmapped reads return zero
    always_comb begin
        case (wb_adr_i)
            `PEC_ADR_SEL:    nxt_datO = sel_ff;
            `PEC_ADR_CNT_LO: nxt_datO = count_ff[31:0];
            `PEC_ADR_CNT_HI: nxt_datO = {24'h00_0000, count_ff[39:32]};
            `PEC_ADR_STATUS: nxt_datO = {27'h000_0000, sOthSnp, snoopPort_ff, coreActive, sOthRun, sRun};
            default:         nxt_datO = 32'h0000_0000;
        endcase
    end

    // Event-select register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= `PEC_SEL_RESET;
        end else if (wrSel) begin
            sel_ff <= laneMerge(sel_ff, wb_dat_i, wb_sel_i);
        end
    end

    // Counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= `PEC_CNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Bus answer: one-cycle ack, data registered with it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= wbReq ? nxt_datO : 32'h0000_0000;
        end
    end

    // Store port, activity and bus tick registers: a cross-core snoop takes the port ahead of a store
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            storeGrant_ff  <= 1'b0;
            snoopPort_ff   <= 1'b0;
            active_ff      <= 1'b0;
            busTickPrev_ff <= 1'b0;
        end else begin
            snoopPort_ff   <= sXSnoop;
            storeGrant_ff  <= sStoreReq & ~sXSnoop;
            active_ff      <= coreActive;
            busTickPrev_ff <= sBusTick;
        end
    end

    assign storeGrant       = storeGrant_ff;
    assign snoopOnStorePort = snoopPort_ff;
    assign counterActive    = active_ff;

    // Counting advances only when enabled and a selected event fires
    count_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!$past(doCount) && !$past(wrCntLo) && !$past(wrCntHi)) |-> count_ff == $past(count_ff))
        else $error("counter moved without a matching event");
    count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (doCount && !wrCntLo && !wrCntHi) |=> count_ff == $past(count_ff) + `PEC_CNT_ONE)
        else $error("counter missed a matching event");
    enable_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !enable |-> !doCount)
        else $error("counted while disabled");
    halt_freeze_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (isUnhalt && !sRun) |-> !doCount)
        else $error("unhalted cycle event counted while halted");
    inactive_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!sRun && !sSnooped) |-> !doCount)
        else $error("count while core inactive");
    snooped_active_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && !sRun && sSnooped && evtCode == `PEC_EV_L2REJ && sRej) |-> doCount)
        else $error("snooped halted core not counting");
    scope_all_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && scope == `PEC_CORE_ALL && evtCode == `PEC_EV_L2REJ && sRejO) |-> doCount)
        else $error("all-core scope missed other core event");
    scope_own_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (scope == `PEC_CORE_THIS && evtCode == `PEC_EV_L2REJ && !sRej) |-> !doCount)
        else $error("own-core scope counted other core");
    idle_scope_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && scope == `PEC_CORE_ALL && evtCode == `PEC_EV_L2IDLE && sIdleO) |-> doCount)
        else $error("all-core scope missed other core idle cycle");
    prefetch_other_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && scope == `PEC_CORE_ALL && evtCode == `PEC_EV_L1PREF
         && lowMask == `PEC_UM_CORECYC && sPrefO) |-> doCount)
        else $error("all-core scope missed other core prefetch");

    // Each selected condition adds one while the core is active
    refuse_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_L2REJ && sRej) |-> doCount)
        else $error("refused cycle not counted");
    idle_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_L2IDLE && sIdle) |-> doCount)
        else $error("idle request cycle not counted");
    prefetch_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_L1PREF && uMask == `PEC_UM_CORECYC && sPref) |-> doCount)
        else $error("prefetch request not counted");
    xsnoop_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_XSNOOP && uMask == `PEC_UM_REFCYC && sXSnoop) |-> doCount)
        else $error("cross-core snoop not counted");
    snoop_resp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_BUSSNP && uMask == `PEC_UM_CORECYC && sSnpResp) |-> doCount)
        else $error("snoop response not counted");
    ready_all_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_DRDY && uMask == `PEC_UM_ALLAGENT && sDrdyAny) |-> doCount)
        else $error("any-agent data ready not counted");

    // Cycle events follow the running core and the bus clock edges
    core_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && isUnhalt && uMask == `PEC_UM_CORECYC && sRun) |-> doCount)
        else $error("running core cycle not counted");
    ref_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && isUnhalt && uMask == `PEC_UM_REFCYC && sRun && busEdge) |-> doCount)
        else $error("reference bus cycle not counted");
    ref_tick_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (isUnhalt && uMask == `PEC_UM_REFCYC && !busEdge) |-> !doCount)
        else $error("reference cycle counted without bus edge");
    serial_other_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (isUnhalt && uMask == `PEC_UM_SERIAL && sOthRun) |-> !doCount)
        else $error("serial cycle counted while other core runs");
    bus_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (evtCode == `PEC_EV_BUSIDLE && sBusOut) |-> !doCount)
        else $error("bus idle counted with outstanding transaction");
    bus_idle_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && coreActive && evtCode == `PEC_EV_BUSIDLE && uMask == `PEC_UM_CORECYC
         && !sBusOut && busEdge) |-> doCount)
        else $error("idle bus cycle not counted");

    // Store port and bus answer
    store_yield_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sXSnoop |=> !storeGrant && snoopOnStorePort)
        else $error("store granted during cross-core snoop");
    wb_ack_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

// ---- verilog/pec_params.svh ----
// Register offsets, field positions, event codes and reset values of the event counter
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH
`define PEC_ADR_SEL      4'h0
`define PEC_ADR_CNT_LO   4'h1
`define PEC_ADR_CNT_HI   4'h2
`define PEC_ADR_STATUS   4'h3
`define PEC_SEL_RESET    32'h0000_0000
`define PEC_EVT_LSB      0
`define PEC_EVT_MSB      7
`define PEC_UMASK_LSB    8
`define PEC_UMASK_MSB    15
`define PEC_CORE_LSB     14
`define PEC_CORE_MSB     15
`define PEC_EN_BIT       22
`define PEC_EV_L2REJ     8'h30
`define PEC_EV_L2IDLE    8'h32
`define PEC_EV_UNHALT    8'h3C
`define PEC_EV_L1PREF    8'h4F
`define PEC_EV_BUSSNP    8'h77
`define PEC_EV_XSNOOP    8'h78
`define PEC_EV_BUSIDLE   8'h7D
`define PEC_EV_DRDY      8'h62
`define PEC_UM_CORECYC   8'h00
`define PEC_UM_REFCYC    8'h01
`define PEC_UM_SERIAL    8'h02
`define PEC_UM_ALLAGENT  8'h20
`define PEC_CORE_ALL     2'h3
`define PEC_CORE_THIS    2'h1
`define PEC_CNT_RESET    40'h00_0000_0000
`define PEC_CNT_ONE      40'h00_0000_0001
`endif

// ---- verilog/pec_pkg.sv ----
// Types shared by the event counter files
package pec_pkg;
    typedef logic [7:0]  pec_code_t;
    typedef logic [39:0] pec_count_t;
    typedef logic [31:0] pec_word_t;
endpackage

// ---- verilog/pec_sync.sv ----
// Two-flip-flop synchroniser for a vector of asynchronous condition inputs
`timescale 1ns/1ps
module pec_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_ff <= '0;
            syncOut   <= '0;
        end else begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule

// ---- verif/tb_pec_counter.sv ----
// Self-checking testbench for the per-core event counter
`timescale 1ns/1ps
`include "pec_params.svh"
module tb_pec_counter;
    import pec_pkg::*;
    typedef struct {
        pec_code_t  code;
        pec_code_t  um;
        logic [16:0] base;
        int         p;
        logic       q;
        pec_word_t  pre;
    } pec_tb_case_t;
    localparam int LIMIT = 30000;
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        wbCyc   = 1'b0;
    logic        wbStb   = 1'b0;
    logic        wbWe    = 1'b0;
    logic [3:0]  wbAdr   = 4'h0;
    logic [3:0]  wbSel   = 4'h0;
    pec_word_t   wbDat   = 32'h0000_0000;
    pec_word_t   wbRd;
    logic        wbAck;
    logic        storeGrant;
    logic        snoopOnStorePort;
    logic        counterActive;
    logic [16:0] cond    = 17'h00000;
    int          errors  = 0;
    int          comparisons = 0;
    int          cycles  = 0;
    int          seed    = 29;
    pec_tb_case_t cases[21];
    // Clock at 200 MHz
    always #2.5 sys_clk = ~sys_clk;
    pec_counter i_pec_counter (
        .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbRd), .wb_ack_o(wbAck),
        .coreRunning(cond[0]), .coreSnooped(cond[1]), .otherCoreRunning(cond[2]),
        .otherCoreSnooped(cond[3]), .busClockTick(cond[4]), .cacheRefuse(cond[5]),
        .cacheRefuseOther(cond[6]), .cacheIdleRequest(cond[7]), .cacheIdleRequestOther(cond[8]),
        .prefetchRequest(cond[9]), .prefetchRequestOther(cond[10]), .crossCoreSnoop(cond[11]),
        .busOutstanding(cond[12]), .busDataReadyOwn(cond[13]), .busDataReadyAny(cond[14]),
        .snoopResponse(cond[15]), .storeRequest(cond[16]), .storeGrant(storeGrant),
        .snoopOnStorePort(snoopOnStorePort), .counterActive(counterActive)
    );
    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            complete_run();
        end
    end
    task automatic checkCount(input string what, input pec_count_t exp, input pec_count_t seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic checkBit(input string what, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Classic Wishbone single cycle; held until ack is sampled high
    task automatic wbCycle(input logic we, input logic [3:0] adr, input pec_word_t dat, output pec_word_t rdat);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDat <= dat;
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        rdat = wbRd;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask
    // Bit 4 gives k bus clock rising edges; other bits are held high for k cycles
    task automatic pulseCond(input int p, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge sys_clk) cond[p] <= 1'b1;
            if (p == 4) begin
                @(posedge sys_clk);
                @(posedge sys_clk) cond[p] <= 1'b0;
                @(posedge sys_clk);
            end
        end
        @(posedge sys_clk) cond[p] <= 1'b0;
    endtask
    // Expected count from the case table
    function automatic pec_count_t expCount(input pec_tb_case_t tc, input int k);
        return tc.q ? ({8'h00, tc.pre} + 40'(k)) : {8'h00, tc.pre};
    endfunction
    initial begin
        pec_word_t lo;
        pec_word_t hi;
        int k;
        cases[0]  = '{`PEC_EV_L2REJ, 8'h00, 17'h00001, 5, 1'b1, 32'h0};
        cases[1]  = '{`PEC_EV_L2REJ, 8'h00, 17'h00000, 5, 1'b0, 32'h0};
        cases[2]  = '{`PEC_EV_L2REJ, 8'h00, 17'h00002, 5, 1'b1, 32'h0};
        cases[3]  = '{`PEC_EV_L2REJ, 8'hC0, 17'h00001, 6, 1'b1, 32'h0};
        cases[4]  = '{`PEC_EV_L2REJ, 8'h40, 17'h00001, 6, 1'b0, 32'h0};
        cases[5]  = '{`PEC_EV_L2IDLE, 8'h00, 17'h00001, 7, 1'b1, 32'h0};
        cases[6]  = '{`PEC_EV_UNHALT, `PEC_UM_CORECYC, 17'h00000, 0, 1'b1, 32'h0};
        cases[7]  = '{`PEC_EV_UNHALT, `PEC_UM_CORECYC, 17'h00000, 1, 1'b0, 32'h0};
        cases[8]  = '{`PEC_EV_UNHALT, `PEC_UM_REFCYC, 17'h00001, 4, 1'b1, 32'h0};
        cases[9]  = '{`PEC_EV_UNHALT, `PEC_UM_REFCYC, 17'h00002, 4, 1'b0, 32'h0};
        cases[10] = '{`PEC_EV_UNHALT, `PEC_UM_SERIAL, 17'h00001, 4, 1'b1, 32'h0};
        cases[11] = '{`PEC_EV_UNHALT, `PEC_UM_SERIAL, 17'h00005, 4, 1'b0, 32'h0};
        cases[12] = '{`PEC_EV_L1PREF, 8'h00, 17'h00001, 9, 1'b1, 32'hFFFF_FFFE};
        cases[13] = '{`PEC_EV_L1PREF, 8'h01, 17'h00001, 9, 1'b0, 32'h0};
        cases[14] = '{`PEC_EV_XSNOOP, 8'h01, 17'h00001, 11, 1'b1, 32'h0};
        cases[15] = '{`PEC_EV_BUSIDLE, 8'h00, 17'h00001, 4, 1'b1, 32'h0};
        cases[16] = '{`PEC_EV_BUSIDLE, 8'h00, 17'h01001, 4, 1'b0, 32'h0};
        cases[17] = '{`PEC_EV_BUSSNP, 8'h00, 17'h00001, 15, 1'b1, 32'h0};
        cases[18] = '{`PEC_EV_DRDY, `PEC_UM_ALLAGENT, 17'h00001, 14, 1'b1, 32'h0};
        cases[19] = '{`PEC_EV_DRDY, 8'h00, 17'h00001, 14, 1'b0, 32'h0};
        cases[20] = '{`PEC_EV_DRDY, 8'h00, 17'h00001, 13, 1'b1, 32'h0};
        // Reset for four cycles
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        wbCycle(1'b0, `PEC_ADR_CNT_LO, 32'h0, lo);
        checkCount("count after reset", `PEC_CNT_RESET, {8'h00, lo});
        for (int i = 0; i < 21; i++) begin
            k = 1 + ($unsigned($random(seed)) % 12);
            @(posedge sys_clk) cond <= cases[i].base;
            wbCycle(1'b1, `PEC_ADR_SEL, {9'h000, 1'b1, 6'h00, cases[i].um, cases[i].code}, lo);
            repeat (4) @(posedge sys_clk);
            wbCycle(1'b1, `PEC_ADR_CNT_HI, 32'h0, lo);
            wbCycle(1'b1, `PEC_ADR_CNT_LO, cases[i].pre, lo);
            pulseCond(cases[i].p, k);
            repeat (6) @(posedge sys_clk);
            wbCycle(1'b0, `PEC_ADR_CNT_LO, 32'h0, lo);
            wbCycle(1'b0, `PEC_ADR_CNT_HI, 32'h0, hi);
            checkCount("count", expCount(cases[i], k), {hi[7:0], lo});
            $display("test %0d done", i);
        end
        // Snoop takes the store port from an ordinary store
        @(posedge sys_clk) cond <= 17'h10801;
        repeat (5) @(posedge sys_clk);
        checkBit("storeGrant with snoop", 1'b0, storeGrant);
        checkBit("snoopOnStorePort", 1'b1, snoopOnStorePort);
        checkBit("counterActive", 1'b1, counterActive);
        @(posedge sys_clk) cond <= 17'h10001;
        repeat (5) @(posedge sys_clk);
        checkBit("storeGrant without snoop", 1'b1, storeGrant);
        wbCycle(1'b0, `PEC_ADR_STATUS, 32'h0, lo);
        checkCount("status", 40'h00_0000_0005, {36'h0, lo[3:0]});
        wbCycle(1'b0, 4'h7, 32'h0, lo);
        checkCount("unmapped read", `PEC_CNT_RESET, {8'h00, lo});
        @(posedge sys_clk) cond <= 17'h00002;
        repeat (5) @(posedge sys_clk);
        checkBit("counterActive snooped", 1'b1, counterActive);
        @(posedge sys_clk) cond <= 17'h00000;
        repeat (5) @(posedge sys_clk);
        checkBit("counterActive idle", 1'b0, counterActive);
        checkBit("storeGrant idle", 1'b0, storeGrant);
        $display("test store port and status done");
        complete_run();
    end
endmodule
